// ==== rtl/fpgp_pkg.sv ====
// Operation
// - input pin: data read returns synchronised level
// - output pin: data read returns latch
// - writes load latch; outputs drive latch
// - reset clears latch, pins stay inputs
// - direction bit enables driver, selects read
// - pull-up bit enables pull-up when set
// - output pin forces pull-up off
// - slew bit enables slew limiting when set
// - input pin ignores slew bit
// - drive bit selects low or high drive
package fpgp_pkg;
  localparam logic [7:0] FPGP_IMPL_MASK  = 8'h33;
  localparam logic [7:0] FPGP_RESET_VAL  = 8'h00;
  localparam logic [4:0] FPGP_OFF_DATA   = 5'h00;
  localparam logic [4:0] FPGP_OFF_DIR    = 5'h04;
  localparam logic [4:0] FPGP_OFF_PULLUP = 5'h08;
  localparam logic [4:0] FPGP_OFF_SLEW   = 5'h0C;
  localparam logic [3:0] FPGP_ADDR_W     = 4'h5;
  localparam logic [4:0] FPGP_OFF_DRIVE  = 5'h10;
  localparam logic [1:0] FPGP_RESP_OKAY  = 2'h0;
  localparam logic [1:0] FPGP_RESP_SLVERR = 2'h2;
endpackage : fpgp_pkg

// ==== rtl/fpgp_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module fpgp_sync (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] async_in,
  output logic      [7:0] sync_out
);
  logic [7:0] meta_ff;
  logic [7:0] nxt_meta;
  logic [7:0] nxt_sync;

  always_comb begin
    nxt_meta = aresetn ? async_in : fpgp_pkg::FPGP_RESET_VAL;
    nxt_sync = aresetn ? meta_ff : fpgp_pkg::FPGP_RESET_VAL;
  end

  // first stage feeds only the second
  always_ff @(posedge aclk) begin
    meta_ff  <= nxt_meta;
    sync_out <= nxt_sync;
  end
endmodule : fpgp_sync
`default_nettype wire

// ==== rtl/fpgp_port.sv ====
`timescale 1ns/10ps
`default_nettype none
module fpgp_port (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  pin_in,
  output logic [7:0]       pin_out,
  output logic [7:0]       pin_oe_n,
  output logic [7:0]       pin_pullup_en,
  output logic [7:0]       pin_slew_en,
  output logic [7:0]       pin_drive_high
);
  localparam logic [7:0] MASK = fpgp_pkg::FPGP_IMPL_MASK;

  logic [7:0]  pin_sync;
  logic [7:0]  port_data_latch_ff, nxt_port_data_latch;
  logic [7:0]  port_direction_ff, nxt_port_direction;
  logic [7:0]  port_pullup_enable_ff, nxt_port_pullup_enable;
  logic [7:0]  port_slew_enable_ff, nxt_port_slew_enable;
  logic [7:0]  port_drive_strength_ff, nxt_port_drive_strength;
  logic        aw_held_ff, nxt_aw_held;
  logic        w_held_ff, nxt_w_held;
  logic [4:0]  awaddr_ff, nxt_awaddr;
  logic [7:0]  wbyte_ff, nxt_wbyte;
  logic        wlane_ff, nxt_wlane;
  logic        bvalid_ff, nxt_bvalid;
  logic [1:0]  bresp_ff, nxt_bresp;
  logic        rvalid_ff, nxt_rvalid;
  logic [1:0]  rresp_ff, nxt_rresp;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        do_write;
  logic [7:0]  wr_val;
  logic [7:0]  rd_val;
  logic        rd_hit;

  fpgp_sync u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (pin_in),
    .sync_out (pin_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data taken in either order
  assign s_axi_awready = ~aw_held_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_held_ff & ~bvalid_ff;
  assign do_write      = aw_held_ff & w_held_ff & ~bvalid_ff;
  assign wr_val        = wbyte_ff & MASK;

  always_comb begin
    nxt_aw_held = aw_held_ff;
    nxt_w_held  = w_held_ff;
    nxt_awaddr  = awaddr_ff;
    nxt_wbyte   = wbyte_ff;
    nxt_wlane   = wlane_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_held = 1'b1;
      nxt_awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_held = 1'b1;
      nxt_wbyte  = s_axi_wdata[7:0];
      nxt_wlane  = s_axi_wstrb[0];
    end
    if (do_write) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = (awaddr_ff > fpgp_pkg::FPGP_OFF_DRIVE[4:0] || awaddr_ff[1:0] != 2'h0)
                    ? fpgp_pkg::FPGP_RESP_SLVERR : fpgp_pkg::FPGP_RESP_OKAY;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (!aresetn) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_awaddr  = 5'h00;
      nxt_wbyte   = 8'h00;
      nxt_wlane   = 1'b0;
      nxt_bvalid  = 1'b0;
      nxt_bresp   = 2'h0;
    end
  end

  always_ff @(posedge aclk) begin
    aw_held_ff <= nxt_aw_held;
    w_held_ff  <= nxt_w_held;
    awaddr_ff  <= nxt_awaddr;
    wbyte_ff   <= nxt_wbyte;
    wlane_ff   <= nxt_wlane;
    bvalid_ff  <= nxt_bvalid;
    bresp_ff   <= nxt_bresp;
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  ////////////////////////////////////////////////////////////////////////////
  // port registers
  always_comb begin
    nxt_port_data_latch     = port_data_latch_ff;
    nxt_port_direction      = port_direction_ff;
    nxt_port_pullup_enable  = port_pullup_enable_ff;
    nxt_port_slew_enable    = port_slew_enable_ff;
    nxt_port_drive_strength = port_drive_strength_ff;
    // lane 0 strobe gates the byte; other lanes carry nothing
    if (do_write && wlane_ff) begin
      if (awaddr_ff == fpgp_pkg::FPGP_OFF_DATA) begin
        nxt_port_data_latch = wr_val;
      end else if (awaddr_ff == fpgp_pkg::FPGP_OFF_DIR) begin
        nxt_port_direction = wr_val;
      end else if (awaddr_ff == fpgp_pkg::FPGP_OFF_PULLUP) begin
        nxt_port_pullup_enable = wr_val;
      end else if (awaddr_ff == fpgp_pkg::FPGP_OFF_SLEW) begin
        nxt_port_slew_enable = wr_val;
      end else if (awaddr_ff == fpgp_pkg::FPGP_OFF_DRIVE[4:0]) begin
        nxt_port_drive_strength = wr_val;
      end
    end
    if (!aresetn) begin
      nxt_port_data_latch     = fpgp_pkg::FPGP_RESET_VAL;
      nxt_port_direction      = fpgp_pkg::FPGP_RESET_VAL;
      nxt_port_pullup_enable  = fpgp_pkg::FPGP_RESET_VAL;
      nxt_port_slew_enable    = fpgp_pkg::FPGP_RESET_VAL;
      nxt_port_drive_strength = fpgp_pkg::FPGP_RESET_VAL;
    end
  end

  always_ff @(posedge aclk) begin
    port_data_latch_ff     <= nxt_port_data_latch;
    port_direction_ff      <= nxt_port_direction;
    port_pullup_enable_ff  <= nxt_port_pullup_enable;
    port_slew_enable_ff    <= nxt_port_slew_enable;
    port_drive_strength_ff <= nxt_port_drive_strength;
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad controls, all straight from flops; MASK on all but pin_out, direction gates pin_out, pull-up and slew
  assign pin_out        = port_data_latch_ff & port_direction_ff;
  assign pin_oe_n       = ~(port_direction_ff & MASK);
  assign pin_pullup_en  = port_pullup_enable_ff & ~port_direction_ff & MASK;
  assign pin_slew_en    = port_slew_enable_ff & port_direction_ff & MASK;
  assign pin_drive_high = port_drive_strength_ff & MASK;

  ////////////////////////////////////////////////////////////////////////////
  // read channel: one cycle to rvalid
  assign s_axi_arready = ~rvalid_ff;

  always_comb begin
    rd_val = 8'h00;
    rd_hit = 1'b1;
    if (s_axi_araddr == fpgp_pkg::FPGP_OFF_DATA) begin
      // latch for outputs, synchronised pin for inputs
      rd_val = (port_direction_ff & port_data_latch_ff) | (~port_direction_ff & pin_sync);
    end else if (s_axi_araddr == fpgp_pkg::FPGP_OFF_DIR) begin
      rd_val = port_direction_ff;
    end else if (s_axi_araddr == fpgp_pkg::FPGP_OFF_PULLUP) begin
      rd_val = port_pullup_enable_ff;
    end else if (s_axi_araddr == fpgp_pkg::FPGP_OFF_SLEW) begin
      rd_val = port_slew_enable_ff;
    end else if (s_axi_araddr == fpgp_pkg::FPGP_OFF_DRIVE[4:0]) begin
      rd_val = port_drive_strength_ff;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rresp  = rresp_ff;
    nxt_rdata  = rdata_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = {24'h000000, rd_val & MASK};
      nxt_rresp  = rd_hit ? fpgp_pkg::FPGP_RESP_OKAY : fpgp_pkg::FPGP_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
    if (!aresetn) begin
      nxt_rvalid = 1'b0;
      nxt_rresp  = 2'h0;
      nxt_rdata  = 32'h00000000;
    end
  end

  always_ff @(posedge aclk) begin
    rvalid_ff <= nxt_rvalid;
    rresp_ff  <= nxt_rresp;
    rdata_ff  <= nxt_rdata;
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp  = rresp_ff;
  assign s_axi_rdata  = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_unused_zero;
    @(posedge aclk) disable iff (!aresetn)
      ((port_data_latch_ff | port_direction_ff | port_pullup_enable_ff |
        port_slew_enable_ff | port_drive_strength_ff) & ~MASK) == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit holds state");

  property p_read_zero_top;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0 && s_axi_rdata[3:2] == 2'h0;
  endproperty
  a_read_zero_top: assert property (p_read_zero_top) else $error("unused read bits nonzero");

  property p_data_write;
    @(posedge aclk) disable iff (!aresetn)
      (do_write && wlane_ff && awaddr_ff == fpgp_pkg::FPGP_OFF_DATA)
        |=> port_data_latch_ff == ($past(wbyte_ff) & MASK);
  endproperty
  a_data_write: assert property (p_data_write) else $error("latch not updated");

  // control writes reach the pads one edge after do_write
  property p_dir_write;
    @(posedge aclk) disable iff (!aresetn)
      (do_write && wlane_ff && awaddr_ff == fpgp_pkg::FPGP_OFF_DIR)
        |=> pin_oe_n == ~($past(wbyte_ff) & MASK);
  endproperty
  a_dir_write: assert property (p_dir_write) else $error("direction not applied");

  property p_pullup_write;
    @(posedge aclk) disable iff (!aresetn)
      (do_write && wlane_ff && awaddr_ff == fpgp_pkg::FPGP_OFF_PULLUP)
        |=> pin_pullup_en == ($past(wbyte_ff) & MASK & ~port_direction_ff);
  endproperty
  a_pullup_write: assert property (p_pullup_write) else $error("pull-up not applied");

  property p_slew_write;
    @(posedge aclk) disable iff (!aresetn)
      (do_write && wlane_ff && awaddr_ff == fpgp_pkg::FPGP_OFF_SLEW)
        |=> pin_slew_en == ($past(wbyte_ff) & MASK & port_direction_ff);
  endproperty
  a_slew_write: assert property (p_slew_write) else $error("slew not applied");

  property p_drive_write;
    @(posedge aclk) disable iff (!aresetn)
      (do_write && wlane_ff && awaddr_ff == fpgp_pkg::FPGP_OFF_DRIVE)
        |=> pin_drive_high == ($past(wbyte_ff) & MASK);
  endproperty
  a_drive_write: assert property (p_drive_write) else $error("drive not applied");

  property p_out_drive;
    @(posedge aclk) disable iff (!aresetn)
      (pin_out & ~pin_oe_n) == (port_data_latch_ff & ~pin_oe_n);
  endproperty
  a_out_drive: assert property (p_out_drive) else $error("driven level wrong");

  property p_reset_clear;
    @(posedge aclk) !aresetn |=> port_data_latch_ff == 8'h00 && pin_oe_n == 8'hFF && pin_pullup_en == 8'h00;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset state wrong");

  property p_pullup_gate;
    @(posedge aclk) disable iff (!aresetn)
      (pin_pullup_en & port_direction_ff) == 8'h00 && (pin_pullup_en == (port_pullup_enable_ff & ~port_direction_ff & MASK));
  endproperty
  a_pullup_gate: assert property (p_pullup_gate) else $error("pull-up on output pin");

  property p_slew_gate;
    @(posedge aclk) disable iff (!aresetn)
      (pin_slew_en & ~port_direction_ff) == 8'h00;
  endproperty
  a_slew_gate: assert property (p_slew_gate) else $error("slew on input pin");

  property p_read_out;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == fpgp_pkg::FPGP_OFF_DATA)
        |=> s_axi_rdata[7:0] == (($past(port_direction_ff) & $past(port_data_latch_ff) |
                                  ~$past(port_direction_ff) & $past(pin_sync)) & MASK);
  endproperty
  a_read_out: assert property (p_read_out) else $error("data read wrong");

  property p_read_pin;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == fpgp_pkg::FPGP_OFF_DATA)
        |=> ((s_axi_rdata[7:0] ^ $past(pin_sync)) & ~$past(port_direction_ff) & MASK) == 8'h00;
  endproperty
  a_read_pin: assert property (p_read_pin) else $error("input pin level not read");

  property p_bresp_follow;
    @(posedge aclk) disable iff (!aresetn)
      do_write |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_bresp_follow: assert property (p_bresp_follow) else $error("write not answered");
endmodule : fpgp_port
`default_nettype wire

// ==== verif/fpgp_pad_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module fpgp_pad_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pin_pullup_en,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  output logic      [7:0] pin_lvl
);
  logic [7:0] float_ff;
  // floating pads wander so a stale level never passes for data
  always_ff @(posedge aclk) begin
    if (!aresetn) float_ff <= 8'hA5;
    else float_ff <= ~float_ff;
  end
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (!pin_oe_n[b]) pin_lvl[b] = pin_out[b];
      else if (ext_en[b]) pin_lvl[b] = ext_val[b];
      else if (pin_pullup_en[b]) pin_lvl[b] = 1'b1;
      else pin_lvl[b] = float_ff[b];
    end
  end
endmodule : fpgp_pad_model
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fail_count++; $display("ERROR %0t: got %h exp %h", $time, a, e); end end
module tb;
  localparam logic [7:0] M = fpgp_pkg::FPGP_IMPL_MASK;
  localparam logic [1:0] OK = fpgp_pkg::FPGP_RESP_OKAY;
  localparam logic [1:0] SE = fpgp_pkg::FPGP_RESP_SLVERR;
  logic             aclk, aresetn, awvalid, wvalid, arvalid;
  logic [4:0]       awaddr, araddr;
  logic [31:0]      wdata, seed;
  logic [3:0]       wstrb;
  logic [7:0]       ext_val, ext_en, lvl;
  logic [7:0]       rv [5];
  logic [33:0]      qr [$];
  logic [1:0]       qb [$];
  logic [33:0]      er;
  logic [1:0]       eb;
  wire logic        awready, wready, bvalid, arready, rvalid;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [7:0]  pin_in, pin_out, pin_oe_n, pin_pu, pin_se, pin_ds;
  int               fail_count, checks;
  fpgp_port i_fpgp_port (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(1'b1), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .pin_pullup_en(pin_pu), .pin_slew_en(pin_se), .pin_drive_high(pin_ds));
  fpgp_pad_model i_fpgp_pad_model (.aclk(aclk), .aresetn(aresetn), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pin_pullup_en(pin_pu), .ext_val(ext_val), .ext_en(ext_en), .pin_lvl(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : xs
  task automatic end_of_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic tmo();
    fail_count++;
    $display("ERROR %0t: bus wait ran out", $time);
    end_of_test();
  endtask : tmo
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d, input logic [3:0] s, input logic [1:0] r);
    int  n;
    logic ta, tw, td;
    qb.push_back(r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h000000, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = awready;
      tw = wready;
      td = bvalid;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (td) break;
    end
    if (n == 50) tmo();
  endtask : bus_wr
  task automatic bus_rd(input logic [4:0] a, input logic [7:0] e, input logic [1:0] r);
    int  n;
    logic ta, td;
    qr.push_back({r, 24'h000000, e});
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(negedge aclk);
      ta = arready;
      td = rvalid;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (td) break;
    end
    if (n == 50) tmo();
  endtask : bus_rd
  // direction set on every implemented pin exposes the cleared latch
  task automatic chk_reset();
    for (int i = 1; i < 5; i++) bus_rd(5'(4 * i), 8'h00, OK);
    bus_wr(fpgp_pkg::FPGP_OFF_DIR, M, 4'hF, OK);
    @(negedge aclk);
    `CHK(pin_out, 8'h00)
    `CHK(pin_oe_n, 8'hCC)
    bus_rd(fpgp_pkg::FPGP_OFF_DATA, 8'h00, OK);
  endtask : chk_reset
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    // pop once: the compare macro names its expected value twice
    if (aresetn && bvalid) begin
      eb = qb.pop_front();
      `CHK(bresp, eb)
    end
    if (aresetn && rvalid) begin
      er = qr.pop_front();
      `CHK(rresp, er[33:32])
      if (er[33:32] === OK) `CHK(rdata, er[31:0])
    end
  end
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid, awaddr, araddr, wdata, wstrb} = '0;
    {ext_val, ext_en, fail_count, checks} = '0;
    seed = 32'h0000002F;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK(pin_oe_n, 8'hFF)
    `CHK(pin_pu, 8'h00)
    chk_reset();
    for (int it = 0; it < 30; it++) begin
      for (int i = 0; i < 5; i++) begin
        rv[i] = xs() & M;
        bus_wr(5'(4 * i), rv[i], 4'hF, OK);
      end
      // every input pad is driven or pulled, so its level is known
      ext_en  <= xs() | ~rv[2];
      ext_val <= xs();
      repeat (4) @(posedge aclk);
      @(negedge aclk);
      `CHK(pin_oe_n, ~(rv[1] & M))
      `CHK(pin_out, rv[0] & rv[1])
      `CHK(pin_pu, rv[2] & ~rv[1])
      `CHK(pin_se, rv[3] & rv[1])
      `CHK(pin_ds, rv[4])
      lvl = (ext_val & ext_en) | ~ext_en;
      bus_rd(fpgp_pkg::FPGP_OFF_DATA, (rv[0] & rv[1]) | (lvl & ~rv[1] & M), OK);
      for (int i = 1; i < 5; i++) bus_rd(5'(4 * i), rv[i], OK);
    end
    bus_wr(fpgp_pkg::FPGP_OFF_DIR, 8'hFF, 4'hF, OK);
    bus_rd(fpgp_pkg::FPGP_OFF_DIR, M, OK);
    bus_wr(fpgp_pkg::FPGP_OFF_DIR, 8'h00, 4'hE, OK);
    bus_wr(5'h02, 8'h00, 4'hF, SE);
    bus_rd(5'h14, 8'h00, SE);
    bus_rd(fpgp_pkg::FPGP_OFF_DIR, M, OK);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    `CHK(pin_oe_n, 8'hFF)
    chk_reset();
    end_of_test();
  end
endmodule : tb
`undef CHK
`default_nettype wire
